// File: verilog/charger_pkg.sv
// Shared constants, carriers and state type for the charger register bank
package charger_pkg;

  // Register offsets on the two-wire port
  localparam logic [7:0] CTRL_ADDR   = 8'h07;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] FAULT_ADDR  = 8'h09;

  localparam logic [7:0] CTRL_RESET = 8'h4B;

  // Control field positions
  localparam int CTRL_DETECT_BIT = 7;
  localparam int CTRL_HALF_BIT   = 6;
  localparam int CTRL_SWOFF_BIT  = 5;
  localparam int CTRL_CHG_EN_BIT = 1;
  localparam int CTRL_BAT_EN_BIT = 0;

  // Field encodings
  localparam logic [1:0] SRC_BOOST       = 2'h3;
  localparam logic [1:0] CHG_FAULT_NONE  = 2'h0;
  localparam logic [1:0] CHG_FAULT_INPUT = 2'h1;
  localparam logic [1:0] CHG_FAULT_THERM = 2'h2;
  localparam logic [1:0] CHG_FAULT_TIMER = 2'h3;

  // Bus slave address, value arbitrary
  localparam logic [6:0] BUS_DEV_ADDR = 7'h5A;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [3:0] LAST_TX_BIT  = 4'h7;

  typedef struct packed {
    logic [1:0] source_type;
    logic       boost_mode;
    logic [1:0] charge_phase;
    logic       input_voltage_regulation;
    logic       input_current_regulation;
    logic       power_good_flag;
    logic       thermal_regulation_flag;
    logic       min_system_regulation_flag;
  } core_status_s;

  typedef struct packed {
    logic watchdog_expired;
    logic boost_overload;
    logic bus_overvoltage;
    logic battery_too_low;
    logic input_fault;
    logic thermal_shutdown;
    logic timer_expired;
    logic battery_overvoltage;
    logic cold_buck;
    logic hot_buck;
    logic cold_boost;
    logic hot_boost;
  } core_fault_s;

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK,
    S_WDATA, S_WDATA_ACK, S_RDATA, S_RACK
  } bus_state_e;

endpackage : charger_pkg

// File: verilog/fault_latch.sv
// Sticky fault field that clears to its live value on a host read
`timescale 1ns/100ps
`default_nettype none
module fault_latch #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] fault_i,
  input  wire logic         clr_i,
  output logic      [W-1:0] q_o,
  output logic              new_o
);
  import charger_pkg::*;

  logic [W-1:0] q_q;
  logic         empty;
  logic         hit;

  assign empty = ~|q_q;
  assign hit   = |fault_i;

  // Clear reloads the live value, so a fault present at the read survives
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      q_q <= '0;
    end else if (clr_i) begin
      q_q <= fault_i;
    end else if (empty && hit) begin
      q_q <= fault_i;
    end
  end

  assign q_o   = q_q;
  // A fault landing in an empty latch is new even during a read clear
  assign new_o = empty & hit;

  AST_FAULT_HOLD : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (!empty && !clr_i) |=> (q_q == $past(q_q)))
    else $error("latched fault changed without a read");

  AST_CLEAR_ON_READ : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    clr_i |=> (q_q == $past(fault_i)))
    else $error("read did not reload fault from live value");

endmodule : fault_latch
`default_nettype wire

// File: verilog/timer_rate_gate.sv
// Passes safety timer ticks, dropping every other one when slowed
`timescale 1ns/100ps
`default_nettype none
module timer_rate_gate (
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic tick_i,
  input  wire logic slow_i,
  output logic      tick_o
);
  import charger_pkg::*;

  logic skip_q;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      skip_q <= 1'b0;
    end else if (tick_i && slow_i) begin
      skip_q <= ~skip_q;
    end
  end

  assign tick_o = tick_i & ~(slow_i & skip_q);

  AST_NORMAL_RATE : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (tick_i && !slow_i) |-> tick_o)
    else $error("tick dropped at normal rate");

  AST_HALF_RATE : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (tick_i && slow_i && tick_o) ##1 !(tick_i && slow_i) ##1 (tick_i && slow_i) |-> !tick_o)
    else $error("two slowed ticks passed in a row");

endmodule : timer_rate_gate
`default_nettype wire

// File: verilog/charger_regs.sv
// Control, status and latched-fault registers behind the two-wire serial port
`timescale 1ns/100ps
`default_nettype none
module charger_regs (
  input  wire logic                       sys_clk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic                       scl_i,
  input  wire logic                       sda_i,
  output logic                            sda_o,
  output logic                            sda_oe_o,
  input  wire charger_pkg::core_status_s  status_i,
  input  wire charger_pkg::core_fault_s   fault_i,
  input  wire logic                       vbus_present_i,
  input  wire logic                       detect_done_i,
  input  wire logic                       timer_tick_i,
  output logic                            port_detect_req_o,
  output logic                            safety_timer_tick_o,
  output logic                            battery_switch_off_o,
  output logic                            int_o
);
  import charger_pkg::*;

  bus_state_e  state_q;
  logic [3:0]  bit_cnt_q;
  logic [7:0]  shift_q;
  logic [7:0]  tx_q;
  logic [7:0]  ptr_q;
  logic        rw_q;
  logic        mack_q;
  logic        scl_q;
  logic        sda_q;
  logic [7:0]  ctrl_q;
  logic        vbus_q;
  logic        int_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;
  logic        wr_fire;
  logic        rd_load;
  logic        fault_clr;
  logic [7:0]  rd_data;
  logic [7:0]  status_byte;
  logic [7:0]  fault_byte;
  logic [1:0]  chg_code;
  logic        removal;
  logic        slow_timer;
  logic        cold_now;
  logic        hot_now;
  logic        wd_q, boost_q, bat_q, cold_q, hot_q;
  logic [1:0]  chg_q;
  logic        wd_new, boost_new, chg_new, bat_new, cold_new, hot_new;

  // Line sampling; pins arrive synchronous, only edges are derived
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  assign scl_rise   = scl_i & ~scl_q;
  assign scl_fall   = ~scl_i & scl_q;
  assign start_seen = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_seen  = scl_i & scl_q & ~sda_q & sda_i;

  assign wr_fire   = scl_fall && (state_q == S_WDATA) && (bit_cnt_q == BYTE_BITS);
  assign rd_load   = scl_fall && (((state_q == S_ADDR_ACK) && rw_q) || ((state_q == S_RACK) && mack_q));
  // Clear happens when the byte is captured for sending, one read per clear
  assign fault_clr = rd_load && (ptr_q == FAULT_ADDR);

  // Serial slave sequencing: address, pointer, data with auto-increment
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_q   <= S_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'hFF;
      ptr_q     <= 8'h00;
      rw_q      <= 1'b0;
      mack_q    <= 1'b0;
    end else if (start_seen) begin
      state_q   <= S_ADDR;
      bit_cnt_q <= 4'h0;
      tx_q      <= 8'hFF;
    end else if (stop_seen) begin
      state_q <= S_IDLE;
      tx_q    <= 8'hFF;
    end else if (scl_rise) begin
      case (state_q)
        S_ADDR, S_PTR, S_WDATA: begin
          shift_q   <= {shift_q[6:0], sda_i};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        S_RACK: begin
          mack_q <= ~sda_i;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state_q)
        S_ADDR: begin
          if (bit_cnt_q == BYTE_BITS) begin
            if (shift_q[7:1] == BUS_DEV_ADDR) begin
              state_q <= S_ADDR_ACK;
              rw_q    <= shift_q[0];
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        S_PTR: begin
          if (bit_cnt_q == BYTE_BITS) begin
            state_q <= S_PTR_ACK;
            ptr_q   <= shift_q;
          end
        end
        S_WDATA: begin
          if (bit_cnt_q == BYTE_BITS) begin
            state_q <= S_WDATA_ACK;
            ptr_q   <= ptr_q + 8'h01;
          end
        end
        S_ADDR_ACK: begin
          bit_cnt_q <= 4'h0;
          if (rw_q) begin
            state_q <= S_RDATA;
            tx_q    <= rd_data;
            ptr_q   <= ptr_q + 8'h01;
          end else begin
            state_q <= S_PTR;
          end
        end
        S_PTR_ACK, S_WDATA_ACK: begin
          bit_cnt_q <= 4'h0;
          state_q   <= S_WDATA;
        end
        S_RDATA: begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
          tx_q      <= {tx_q[6:0], 1'b1};
          if (bit_cnt_q == LAST_TX_BIT) begin
            state_q <= S_RACK;
          end
        end
        S_RACK: begin
          bit_cnt_q <= 4'h0;
          if (mack_q) begin
            state_q <= S_RDATA;
            tx_q    <= rd_data;
            ptr_q   <= ptr_q + 8'h01;
          end else begin
            state_q <= S_IDLE;
            tx_q    <= 8'hFF;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Open drain: only ever pulls low
  assign sda_o = 1'b0;
  always_comb begin
    case (state_q)
      S_ADDR_ACK, S_PTR_ACK, S_WDATA_ACK: sda_oe_o = 1'b1;
      S_RDATA:                            sda_oe_o = ~tx_q[7];
      default:                            sda_oe_o = 1'b0;
    endcase
  end

  // Control register; a host write in the same cycle beats the self-clear
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_fire && (ptr_q == CTRL_ADDR)) begin
      ctrl_q <= shift_q;
    end else if (detect_done_i) begin
      ctrl_q[CTRL_DETECT_BIT] <= 1'b0;
    end
  end

  // Request stays pending until input power shows up
  assign port_detect_req_o    = ctrl_q[CTRL_DETECT_BIT] & vbus_present_i;
  assign battery_switch_off_o = ctrl_q[CTRL_SWOFF_BIT];

  assign slow_timer = ctrl_q[CTRL_HALF_BIT] & (status_i.input_voltage_regulation |
                      status_i.input_current_regulation | status_i.thermal_regulation_flag);

  timer_rate_gate u_rate (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .tick_i    (timer_tick_i),
    .slow_i    (slow_timer),
    .tick_o    (safety_timer_tick_o)
  );

  // Live status view
  always_comb begin
    status_byte[7:6] = status_i.boost_mode ? SRC_BOOST : status_i.source_type;
    status_byte[5:4] = status_i.charge_phase;
    status_byte[3]   = status_i.input_voltage_regulation | status_i.input_current_regulation;
    status_byte[2]   = status_i.power_good_flag;
    status_byte[1]   = status_i.thermal_regulation_flag;
    status_byte[0]   = status_i.min_system_regulation_flag;
  end

  // Adapter removal edge, one cycle wide so the input code is posted once
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      vbus_q <= 1'b0;
    end else begin
      vbus_q <= vbus_present_i;
    end
  end

  assign removal = vbus_q & ~vbus_present_i;

  // Input fault outranks thermal, thermal outranks timer expiry
  always_comb begin
    if (removal || fault_i.input_fault) begin
      chg_code = CHG_FAULT_INPUT;
    end else if (fault_i.thermal_shutdown) begin
      chg_code = CHG_FAULT_THERM;
    end else if (fault_i.timer_expired) begin
      chg_code = CHG_FAULT_TIMER;
    end else begin
      chg_code = CHG_FAULT_NONE;
    end
  end

  assign cold_now = status_i.boost_mode ? fault_i.cold_boost : fault_i.cold_buck;
  assign hot_now  = status_i.boost_mode ? fault_i.hot_boost : fault_i.hot_buck;

  fault_latch #(.W(1)) u_wd (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .fault_i   (fault_i.watchdog_expired),
    .clr_i     (fault_clr),
    .q_o       (wd_q),
    .new_o     (wd_new)
  );
  fault_latch #(.W(1)) u_boost (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .fault_i   (fault_i.boost_overload | fault_i.bus_overvoltage | fault_i.battery_too_low),
    .clr_i     (fault_clr),
    .q_o       (boost_q),
    .new_o     (boost_new)
  );
  fault_latch #(.W(2)) u_chg (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .fault_i   (chg_code),
    .clr_i     (fault_clr),
    .q_o       (chg_q),
    .new_o     (chg_new)
  );
  fault_latch #(.W(1)) u_bat (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .fault_i   (fault_i.battery_overvoltage),
    .clr_i     (fault_clr),
    .q_o       (bat_q),
    .new_o     (bat_new)
  );
  fault_latch #(.W(1)) u_cold (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .fault_i   (cold_now),
    .clr_i     (fault_clr),
    .q_o       (cold_q),
    .new_o     (cold_new)
  );
  fault_latch #(.W(1)) u_hot (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .fault_i   (hot_now),
    .clr_i     (fault_clr),
    .q_o       (hot_q),
    .new_o     (hot_new)
  );

  assign fault_byte = {wd_q, boost_q, chg_q, bat_q, 1'b0, cold_q, hot_q};

  always_comb begin
    if (ptr_q == CTRL_ADDR) begin
      rd_data = ctrl_q;
    end else if (ptr_q == STATUS_ADDR) begin
      rd_data = status_byte;
    end else if (ptr_q == FAULT_ADDR) begin
      rd_data = fault_byte;
    end else begin
      rd_data = 8'h00;
    end
  end

  // One-cycle interrupt pulse on each newly latched fault; charge and battery faults only when their enable bits are set
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      int_q <= 1'b0;
    end else begin
      int_q <= wd_new | boost_new | cold_new | hot_new |
               (chg_new & ctrl_q[CTRL_CHG_EN_BIT]) |
               (bat_new & ctrl_q[CTRL_BAT_EN_BIT]);
    end
  end

  assign int_o = int_q;

  AST_CTRL_RESET : assert property (@(posedge sys_clk_i)
    sys_rst_i |=> (ctrl_q == CTRL_RESET))
    else $error("control register not at reset value");
  AST_DETECT_CLEAR : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (detect_done_i && !wr_fire) |=> !port_detect_req_o)
    else $error("force detect not cleared after detection");
  AST_SWITCH_OFF : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_fire && (ptr_q == CTRL_ADDR)) |=> (battery_switch_off_o == $past(shift_q[CTRL_SWOFF_BIT])))
    else $error("battery switch off does not follow write");
  AST_CHG_INT : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (chg_new && ctrl_q[CTRL_CHG_EN_BIT]) |=> int_o)
    else $error("enabled charge fault gave no interrupt");
  AST_BAT_INT : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (bat_new && ctrl_q[CTRL_BAT_EN_BIT]) |=> int_o)
    else $error("enabled battery fault gave no interrupt");
  AST_INT_CAUSE : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    int_o |-> $past(wd_new | boost_new | cold_new | hot_new |
                    (chg_new & ctrl_q[CTRL_CHG_EN_BIT]) | (bat_new & ctrl_q[CTRL_BAT_EN_BIT])))
    else $error("interrupt without a new enabled fault");
  AST_REMOVAL_CODE : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (removal && (chg_q == CHG_FAULT_NONE) && !fault_clr) |=> (chg_q == CHG_FAULT_INPUT))
    else $error("adapter removal did not post input fault");
  AST_STATUS_LOAD : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (rd_load && (ptr_q == STATUS_ADDR) && !start_seen && !stop_seen) |=>
      (tx_q[3] == $past(status_i.input_voltage_regulation | status_i.input_current_regulation)))
    else $error("input limit status not reported");

endmodule : charger_regs
`default_nettype wire

// File: bench/i2c_host_model.sv
// Two-wire bus host model driving the charger register port
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model
  import charger_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  import charger_pkg::*;

  // Four cycles per half bit keeps both phases well above the two-sample minimum
  localparam int HALF = 4;

  initial begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic hold();
    repeat (HALF) @(negedge sys_clk_i);
  endtask : hold

  // Data moves one cycle after the clock falls, never while it is high
  task automatic clock_bit(input logic pull, output logic seen);
    sda_pull_o = pull;
    hold();
    scl_o = 1'b1;
    hold();
    seen  = sda_i;
    scl_o = 1'b0;
    @(negedge sys_clk_i);
  endtask : clock_bit

  // Also serves as repeated start from a low clock
  task automatic start();
    sda_pull_o = 1'b0;
    hold();
    scl_o = 1'b1;
    hold();
    sda_pull_o = 1'b1;
    hold();
    scl_o = 1'b0;
    @(negedge sys_clk_i);
  endtask : start

  task automatic stop();
    sda_pull_o = 1'b1;
    hold();
    scl_o = 1'b1;
    hold();
    sda_pull_o = 1'b0;
    hold();
  endtask : stop

  task automatic send_byte(input logic [7:0] b, inout logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(~b[i], s);
    end
    clock_bit(1'b0, s);
    ok = ok & ~s;
  endtask : send_byte

  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data, output logic ok);
    ok = 1'b1;
    start();
    send_byte({BUS_DEV_ADDR, 1'b0}, ok);
    send_byte(ptr, ok);
    send_byte(data, ok);
    stop();
  endtask : write_reg

  // Always a single-byte read, ended by a not-acknowledge
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data, output logic ok);
    logic s;
    ok = 1'b1;
    start();
    send_byte({BUS_DEV_ADDR, 1'b0}, ok);
    send_byte(ptr, ok);
    start();
    send_byte({BUS_DEV_ADDR, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b0, s);
      data[i] = s;
    end
    clock_bit(1'b0, s);
    stop();
  endtask : read_reg

  // Two-byte burst: first byte acknowledged, second ended by a not-acknowledge
  task automatic read_pair(input logic [7:0] ptr, output logic [15:0] data, output logic ok);
    logic s;
    ok = 1'b1;
    start();
    send_byte({BUS_DEV_ADDR, 1'b0}, ok);
    send_byte(ptr, ok);
    start();
    send_byte({BUS_DEV_ADDR, 1'b1}, ok);
    for (int i = 15; i >= 0; i--) begin
      clock_bit(1'b0, s);
      data[i] = s;
      if (i == 8) begin
        clock_bit(1'b1, s);
      end
    end
    clock_bit(1'b0, s);
    stop();
  endtask : read_pair
endmodule : i2c_host_model
`default_nettype wire

// File: bench/charger_control_status_faults_test.sv
// Self-checking bench for the charger control, status and fault registers
`timescale 1ns/100ps
`default_nettype none
module charger_control_status_faults_test;
  import charger_pkg::*;

  logic         sys_clk_i;
  logic         sys_rst_i;
  logic         scl;
  logic         host_pull;
  logic         sda;
  logic         sda_o;
  logic         sda_oe_o;
  core_status_s status_i;
  core_fault_s  fault_i;
  logic         vbus_present_i;
  logic         detect_done_i;
  logic         timer_tick_i;
  logic         port_detect_req_o;
  logic         safety_timer_tick_o;
  logic         battery_switch_off_o;
  logic         int_o;
  int           n_fail;
  int           n_compared;
  int           n_int;
  int           n_tick;
  int           base;
  logic [9:0]   st_in [5];
  logic [15:0]  pair;
  logic         ok_pair;
  logic [7:0]   st_exp [5];
  logic [7:0]   fl_exp [12];

  // Pull-up: the wire is high unless someone pulls it
  assign sda = (sda_oe_o ? sda_o : 1'b1) & ~host_pull;

  charger_regs charger_regs_inst (
    .sys_clk_i           (sys_clk_i),
    .sys_rst_i           (sys_rst_i),
    .scl_i               (scl),
    .sda_i               (sda),
    .sda_o               (sda_o),
    .sda_oe_o            (sda_oe_o),
    .status_i            (status_i),
    .fault_i             (fault_i),
    .vbus_present_i      (vbus_present_i),
    .detect_done_i       (detect_done_i),
    .timer_tick_i        (timer_tick_i),
    .port_detect_req_o   (port_detect_req_o),
    .safety_timer_tick_o (safety_timer_tick_o),
    .battery_switch_off_o(battery_switch_off_o),
    .int_o               (int_o)
  );

  i2c_host_model i2c_host_model_inst (
    .sys_clk_i (sys_clk_i),
    .sda_i     (sda),
    .scl_o     (scl),
    .sda_pull_o(host_pull)
  );

  always #2.5 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i) begin
    if (int_o === 1'b1) n_int++;
    if (safety_timer_tick_o === 1'b1) n_tick++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask : chk

  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i2c_host_model_inst.read_reg(ptr, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, exp);
  endtask : rd

  task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
    logic ok;
    i2c_host_model_inst.write_reg(ptr, data, ok);
    chk({7'h00, ok}, 8'h01);
  endtask : wr

  task automatic ticks(input logic [7:0] exp);
    base = n_tick;
    repeat (8) begin
      timer_tick_i = 1'b1;
      @(negedge sys_clk_i);
      timer_tick_i = 1'b0;
      @(negedge sys_clk_i);
    end
    chk(8'(n_tick - base), exp);
  endtask : ticks

  // One-cycle fault pulse, then two reads: latched value, then live (clear)
  task automatic flt(input int i, input logic [7:0] exp_int);
    base = n_int;
    status_i.boost_mode = (i >= 10);
    fault_i = core_fault_s'(12'h800 >> i);
    @(negedge sys_clk_i);
    fault_i = '0;
    repeat (3) @(negedge sys_clk_i);
    rd(FAULT_ADDR, fl_exp[i]);
    rd(FAULT_ADDR, 8'h00);
    chk(8'(n_int - base), exp_int);
    status_i.boost_mode = 1'b0;
  endtask : flt

  task automatic results();
    $display("Compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  initial begin
    sys_clk_i = 1'b0;
    sys_rst_i = 1'b1;
    status_i = '0;
    fault_i = '0;
    vbus_present_i = 1'b1;
    detect_done_i = 1'b0;
    timer_tick_i = 1'b0;
    n_fail = 0;
    n_compared = 0;
    n_int = 0;
    n_tick = 0;
    st_in = '{10'h000, 10'h135, 10'h24A, 10'h0E0, 10'h104};
    st_exp = '{8'h00, 8'h5D, 8'hAA, 8'hF0, 8'h44};
    fl_exp = '{8'h80, 8'h40, 8'h40, 8'h40, 8'h10, 8'h20, 8'h30, 8'h08, 8'h02, 8'h01, 8'h02, 8'h01};
    repeat (4) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    @(negedge sys_clk_i);
    rd(CTRL_ADDR, CTRL_RESET);
    chk({6'h00, battery_switch_off_o, port_detect_req_o}, 8'h00);
    wr(CTRL_ADDR, 8'hAB);
    chk({6'h00, battery_switch_off_o, port_detect_req_o}, 8'h03);
    detect_done_i = 1'b1;
    @(negedge sys_clk_i);
    detect_done_i = 1'b0;
    rd(CTRL_ADDR, 8'h2B);
    chk({7'h00, port_detect_req_o}, 8'h00);
    wr(CTRL_ADDR, 8'h0B);
    chk({7'h00, battery_switch_off_o}, 8'h00);
    status_i.input_voltage_regulation = 1'b1;
    ticks(8'h08);
    wr(CTRL_ADDR, CTRL_RESET);
    ticks(8'h04);
    status_i.input_voltage_regulation = 1'b0;
    status_i.input_current_regulation = 1'b1;
    ticks(8'h04);
    status_i.input_current_regulation = 1'b0;
    status_i.thermal_regulation_flag = 1'b1;
    ticks(8'h04);
    status_i = '0;
    ticks(8'h08);
    for (int i = 0; i < 5; i++) begin
      status_i = core_status_s'(st_in[i]);
      rd(STATUS_ADDR, st_exp[i]);
    end
    // Burst across control and status exercises the master-acknowledge path
    status_i = core_status_s'(st_in[1]);
    i2c_host_model_inst.read_pair(CTRL_ADDR, pair, ok_pair);
    chk({7'h00, ok_pair}, 8'h01);
    chk(pair[15:8], CTRL_RESET);
    chk(pair[7:0], st_exp[1]);
    status_i = '0;
    wr(STATUS_ADDR, 8'hFF);
    rd(STATUS_ADDR, 8'h00);
    rd(8'h0C, 8'h00);
    for (int i = 0; i < 12; i++) begin
      flt(i, 8'h01);
    end
    base = n_int;
    fault_i.battery_overvoltage = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    rd(FAULT_ADDR, 8'h08);
    rd(FAULT_ADDR, 8'h08);
    fault_i = '0;
    rd(FAULT_ADDR, 8'h08);
    rd(FAULT_ADDR, 8'h00);
    chk(8'(n_int - base), 8'h01);
    base = n_int;
    vbus_present_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    rd(FAULT_ADDR, 8'h10);
    rd(FAULT_ADDR, 8'h00);
    chk(8'(n_int - base), 8'h01);
    vbus_present_i = 1'b1;
    wr(CTRL_ADDR, 8'h48);
    rd(CTRL_ADDR, 8'h48);
    for (int i = 0; i < 12; i++) begin
      flt(i, (i >= 4 && i <= 7) ? 8'h00 : 8'h01);
    end
    results();
  end
endmodule : charger_control_status_faults_test
`default_nettype wire
